// file: inc/erl_map.svh
/*
 * Address map, reset values and timing constants of the egress rate limit
 * register bank. Assumes the includer wants plain `define names only.
 */
`ifndef ERL_MAP_SVH
`define ERL_MAP_SVH

// register addresses on the internal byte-wide register bus
`define ERL_ADDR_TEST_ONE 8'hBF
`define ERL_ADDR_RSV_CTRL 8'hCF
`define ERL_ADDR_P2_Q1 8'hC7
`define ERL_ADDR_P2_Q2 8'hCD
`define ERL_ADDR_P2_Q3 8'hCE
`define ERL_ADDR_P3_Q1 8'hD7
`define ERL_ADDR_P3_Q2 8'hDD
`define ERL_ADDR_P3_Q3 8'hDE
`define ERL_ADDR_P4_Q1 8'hE7
`define ERL_ADDR_P4_Q2 8'hED
`define ERL_ADDR_P4_Q3 8'hEE

// reset and fixed read values
`define ERL_RST_TEST_ONE 8'h80
`define ERL_RST_RSV_CTRL 8'h15
`define ERL_RST_CAP 7'h00
`define ERL_RD_IDLE 8'h00

// cap field
`define ERL_CAP_MSB 6
`define ERL_CAP_LSB 0
`define ERL_CAP_FULL_ALT 7'h64
`define ERL_CAP_MBPS_MAX 7'h63
`define ERL_CAP_SUB_FIRST 7'h65
`define ERL_CAP_SUB_LAST 7'h67
`define ERL_CAP_SUB_BASE 7'h64

// shaper arithmetic, credit in milli-bits, added once per microsecond
`define ERL_MBPS_MBIT_PER_US 18'h003E8
`define ERL_SUB_MBIT_PER_US 18'h00040
`define ERL_BYTE_MBIT 18'h01F40
`define ERL_BUCKET_MBIT 18'h3E800
`define ERL_CLK_PERIOD_NS 25
`define ERL_TICK_NS 1000

`endif

// file: inc/erl_pkg.sv
/*
 * Types and the rate decode function shared by the register bank and the
 * shaper. Assumes erl_map.svh is on the include path.
 */
`default_nettype none
`include "erl_map.svh"

package erl_pkg;
   typedef logic [6:0] erl_code_t;
   typedef logic [17:0] erl_credit_t;
   typedef logic [1:0] erl_port_t;

   typedef enum logic [1:0] {
      ERL_Q0 = 2'h0,
      ERL_Q1 = 2'h1,
      ERL_Q3 = 2'h3,
      ERL_Q2 = 2'h2
   } erl_queue_e;

   // credit added per tick; zero means no cap (full rate)
   function automatic erl_credit_t erl_rate_fn(input erl_code_t code);
      erl_credit_t inc;
      inc = '0;
      if (code != 7'h00 && code <= `ERL_CAP_MBPS_MAX) begin
         inc = 18'(code * `ERL_MBPS_MBIT_PER_US);
      end else if (code >= `ERL_CAP_SUB_FIRST && code <= `ERL_CAP_SUB_LAST) begin
         inc = 18'(7'(code - `ERL_CAP_SUB_BASE) * `ERL_SUB_MBIT_PER_US);
      end
      return inc;
   endfunction : erl_rate_fn
endpackage : erl_pkg

`default_nettype wire

// file: inc/erl_shp_if.sv
/*
 * Link between the register bank and one queue shaper: cap code, tick,
 * byte take strobe and the send permission. Single core_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface erl_shp_if;
   logic [6:0] code;
   logic tick;
   logic take;
   logic allow;

   modport bank (output code, output tick, output take, input allow);
   modport shaper (input code, input tick, input take, output allow);
endinterface : erl_shp_if

`default_nettype wire

// file: rtl/erl_shaper.sv
/*
 * Token bucket for one egress queue. Credit grows by the decoded rate each
 * tick and one byte is spent per take while a cap is set; a full-rate code spends nothing. Assumes take only when allow is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "erl_map.svh"

module erl_shaper (
   input wire logic core_clk,
   input wire logic sys_rst,
   erl_shp_if.shaper shp
);
   import erl_pkg::*;

   erl_credit_t credit_ff;
   erl_credit_t nxt_credit;
   erl_credit_t inc;
   logic [18:0] sum;
   logic unlimited;

   assign inc = erl_rate_fn(shp.code);
   assign unlimited = (inc == '0);
   assign sum = {1'b0, credit_ff} + {1'b0, (shp.tick ? inc : 18'h00000)}
      - {1'b0, ((shp.take && !unlimited) ? `ERL_BYTE_MBIT : 18'h00000)};
   // saturate so an idle queue cannot bank an unbounded burst
   assign nxt_credit = (sum > {1'b0, `ERL_BUCKET_MBIT}) ? `ERL_BUCKET_MBIT : sum[17:0];
   assign shp.allow = unlimited || (credit_ff >= `ERL_BYTE_MBIT);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         credit_ff <= 18'h00000;
      end else begin
         credit_ff <= nxt_credit;
      end
   end
endmodule : erl_shaper

`default_nettype wire

// file: rtl/erl_regs.sv
/*
 * Egress queue rate limit register bank for switch ports 2 to 4, with a
 * per-port byte scheduler driven by the caps. Assumes the register bus and
 * the queue pending/weight inputs are logic on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "erl_map.svh"

// How it works
// - queue 1 cap: 7-bit read/write code in bits 6..0, resets to zero
// - queue 2 cap: 7-bit read/write code in bits 6..0, resets to zero
// - queue 3 cap: 7-bit read/write code in bits 6..0, resets to zero
// - the top queue's outgoing bytes are shaped to the rate its code selects
// - in two-queue mode queue 1 is the high-priority queue
// - in four-queue mode queue 3 is the highest-priority queue
// - four-queue order is 3, then 2, then 1, then 0
// - test register reads 0x80, ignores writes; software leaves it alone
// - codes 1..99 cap at that many Mbps; 0 and 100 mean full rate
// - codes 101, 102, 103 cap at 64, 128, 192 kbps
// - only the top queue is rate exact; lower queues follow weighting
module erl_regs #(
   parameter int NPORT = 3,
   parameter int TICK_CYC = `ERL_TICK_NS / `ERL_CLK_PERIOD_NS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic [NPORT-1:0] four_q_mode,
   input wire logic [4*NPORT-1:0] q_pend,
   input wire logic [4*NPORT-1:0] wt_allow,
   output logic [4*NPORT-1:0] q_grant
);
   import erl_pkg::*;

   localparam int TICK_W = $clog2(TICK_CYC + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

   // cap address of a given port (0 = switch port 2) and queue 1..3
   function automatic logic [7:0] cap_addr_fn(input int p, input int q);
      logic [7:0] a;
      a = `ERL_RD_IDLE;
      case ({p[1:0], q[1:0]})
         4'h1: a = `ERL_ADDR_P2_Q1;
         4'h2: a = `ERL_ADDR_P2_Q2;
         4'h3: a = `ERL_ADDR_P2_Q3;
         4'h5: a = `ERL_ADDR_P3_Q1;
         4'h6: a = `ERL_ADDR_P3_Q2;
         4'h7: a = `ERL_ADDR_P3_Q3;
         4'h9: a = `ERL_ADDR_P4_Q1;
         4'hA: a = `ERL_ADDR_P4_Q2;
         4'hB: a = `ERL_ADDR_P4_Q3;
         default: a = `ERL_RD_IDLE;
      endcase
      return a;
   endfunction : cap_addr_fn

   // tick divider: one-cycle enable each microsecond
   logic [TICK_W-1:0] tick_cnt_ff;
   logic [TICK_W-1:0] nxt_tick_cnt;
   logic tick_ff;
   logic nxt_tick;

   assign nxt_tick = (tick_cnt_ff == TICK_LAST);
   assign nxt_tick_cnt = nxt_tick ? '0 : TICK_W'(tick_cnt_ff + 1'b1);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // cap storage and read mux
   erl_code_t cap_ff [NPORT][3];
   logic [2:0] hit [NPORT];
   logic [7:0] rd_part [NPORT];
   logic [7:0] cap_rd;
   logic [7:0] nxt_rdata;
   logic fixed_test_hit;
   logic fixed_rsv_hit;

   assign fixed_test_hit = (reg_addr == `ERL_ADDR_TEST_ONE);
   assign fixed_rsv_hit = (reg_addr == `ERL_ADDR_RSV_CTRL);

   genvar gp, gq;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port
         for (gq = 0; gq < 3; gq++) begin : g_q
            logic wr_hit;
            assign hit[gp][gq] = (reg_addr == cap_addr_fn(gp, gq + 1));
            assign wr_hit = reg_wr_en && hit[gp][gq];
            always_ff @(posedge core_clk) begin
               if (sys_rst) begin
                  cap_ff[gp][gq] <= `ERL_RST_CAP;
               end else if (wr_hit) begin
                  // bit 7 of the write is dropped
                  cap_ff[gp][gq] <= reg_wdata[`ERL_CAP_MSB:`ERL_CAP_LSB];
               end
            end
         end
         assign rd_part[gp] =
            ({8{hit[gp][0]}} & {1'b0, cap_ff[gp][0]}) |
            ({8{hit[gp][1]}} & {1'b0, cap_ff[gp][1]}) |
            ({8{hit[gp][2]}} & {1'b0, cap_ff[gp][2]});
      end
   endgenerate

   always_comb begin
      cap_rd = `ERL_RD_IDLE;
      for (int p = 0; p < NPORT; p++) begin
         cap_rd = cap_rd | rd_part[p];
      end
   end

   // fixed registers have no storage, so writes cannot disturb them
   assign nxt_rdata = fixed_test_hit ? `ERL_RST_TEST_ONE :
                      fixed_rsv_hit ? `ERL_RST_RSV_CTRL :
                      cap_rd;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= `ERL_RD_IDLE;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= nxt_rdata;
         end
      end
   end

   // per-port shapers and byte scheduler
   // grants gathered into one register so q_grant has a single driver
   logic [4*NPORT-1:0] nxt_grant_all;

   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_sched
         erl_shp_if shp[3] ();
         logic [3:0] pend;
         logic [3:0] wt;
         logic [3:0] ok;
         logic [3:0] nxt_grant;
         logic [3:0] top_oh;
         logic [3:0] in_mode;
         logic [2:0] shp_allow;

         for (gq = 0; gq < 3; gq++) begin : g_shp
            assign shp[gq].code = cap_ff[gp][gq];
            assign shp[gq].tick = tick_ff;
            // only the top queue spends credit; lower ones use weighting
            assign shp[gq].take = nxt_grant[gq + 1] && top_oh[gq + 1];
            assign shp_allow[gq] = shp[gq].allow;
            erl_shaper u_shaper (
               .core_clk(core_clk),
               .sys_rst(sys_rst),
               .shp(shp[gq])
            );
         end

         assign pend = q_pend[4*gp +: 4];
         assign wt = wt_allow[4*gp +: 4];
         // four queues: 3 tops the order; two queues: 1 tops it
         assign top_oh = four_q_mode[gp] ? 4'h8 : 4'h2;
         assign in_mode = four_q_mode[gp] ? 4'hF : 4'h3;
         // top queue is shaped exactly, others pass by their weighting grant
         assign ok[0] = pend[0] && in_mode[0] && wt[0];
         assign ok[1] = pend[1] && in_mode[1] &&
                        (top_oh[1] ? shp_allow[0] : wt[1]);
         assign ok[2] = pend[2] && in_mode[2] && wt[2];
         assign ok[3] = pend[3] && in_mode[3] && shp_allow[2];

         // strict order 3 > 2 > 1 > 0
         assign nxt_grant = ok[3] ? 4'h8 :
                            ok[2] ? 4'h4 :
                            ok[1] ? 4'h2 :
                            ok[0] ? 4'h1 : 4'h0;

         assign nxt_grant_all[4*gp +: 4] = nxt_grant;
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q_grant <= '0;
      end else begin
         q_grant <= nxt_grant_all;
      end
   end

   // queue 2 limit stays stored for software but shapes nothing: in four-queue
   // mode it is never top, and weighting governs it
   // decoded by erl_rate_fn inside each shaper
endmodule : erl_regs

`default_nettype wire

// file: dv/erl_regs_assertions.sv
/* Port checks for erl_regs: read timing, fixed values, grant order.
   Assumes one core_clk domain with synchronous active-high sys_rst. */
`timescale 1ns/1ps
`default_nettype none
module erl_regs_assertions #(
   parameter int NPORT = 3
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rd_valid,
   input wire logic [NPORT-1:0] four_q_mode,
   input wire logic [4*NPORT-1:0] q_pend,
   input wire logic [4*NPORT-1:0] wt_allow,
   input wire logic [4*NPORT-1:0] q_grant
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // rows C..E by columns 7, D, E are exactly the nine cap registers
   wire logic rd_cap = reg_rd_en && reg_addr[7:4] inside {4'hC, 4'hD, 4'hE}
      && reg_addr[3:0] inside {4'h7, 4'hD, 4'hE};
   a_rd_answer_time:
      assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
   a_test_reg_fixed:
      assert property (reg_rd_en && reg_addr == 8'hBF |=> reg_rdata == 8'h80)
      else $error("test register value wrong");
   a_rsv_reg_fixed:
      assert property (reg_rd_en && reg_addr == 8'hCF |=> reg_rdata == 8'h15)
      else $error("reserved register value wrong");
   a_cap_top_bit:
      assert property (rd_cap |=> !reg_rdata[7]) else $error("cap bit 7 set");
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      wire logic [3:0] gr = q_grant[4*p +: 4];
      wire logic [3:0] ok = q_pend[4*p +: 4] & wt_allow[4*p +: 4];
      a_grant_one_hot:
         assert property ($onehot0(gr)) else $error("two grants on one port");
      a_two_q_upper:
         assert property (!$past(four_q_mode[p]) |-> gr[3:2] == 2'h0)
         else $error("upper queue sent in two-queue mode");
      a_q1_below_q2:
         assert property ($past(four_q_mode[p]) && gr[1] |-> !$past(ok[2]))
         else $error("queue 1 passed queue 2");
      a_low_weighted:
         assert property ($past(four_q_mode[p]) && gr[2:0] != 3'h0
            |-> (gr[2:0] & $past(ok[2:0])) != 3'h0) else $error("unweighted low grant");
   end
endmodule : erl_regs_assertions
bind erl_regs erl_regs_assertions #(.NPORT(NPORT)) u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
   .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
   .four_q_mode(four_q_mode), .q_pend(q_pend), .wt_allow(wt_allow), .q_grant(q_grant));
`default_nettype wire

// file: dv/erl_regs_bench.sv
/* Bench for erl_regs: register access, queue order, rate caps.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module erl_regs_bench;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rd_valid;
   logic [2:0] four_q_mode = 3'h7;
   logic [11:0] q_pend = 12'h000;
   logic [11:0] wt_allow = 12'hFFF;
   logic [11:0] q_grant;
   logic [7:0] caps [9] = '{8'hC7, 8'hCD, 8'hCE, 8'hD7, 8'hDD, 8'hDE, 8'hE7, 8'hED, 8'hEE};
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   erl_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .four_q_mode(four_q_mode),
      .q_pend(q_pend), .wt_allow(wt_allow), .q_grant(q_grant));
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      // run needs about 30k cycles
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // inputs move 2 ns after the edge, never on it
   task automatic clk_n(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : clk_n
   task automatic do_reset();
      sys_rst = 1'b1;
      clk_n(10);
      sys_rst = 1'b0;
   endtask : do_reset
   // idle cycle after the strobe so the next call never drives it twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      clk_n(1);
      reg_wr_en = 1'b0;
      clk_n(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd_en = 1'b1;
      clk_n(1);
      reg_rd_en = 1'b0;
      chk("valid and data", {8'h01, e}, {7'h00, reg_rd_valid, reg_rdata});
      clk_n(1);
   endtask : rd
   task automatic t_regs();
      foreach (caps[i]) begin
         rd(caps[i], 8'h00);
         wr(caps[i], 8'hFF - 8'(i));
         rd(caps[i], 8'h7F - 8'(i));
      end
      rd(8'hBF, 8'h80);
      // software may only rewrite the value the register already holds
      wr(8'hBF, 8'h80);
      rd(8'hBF, 8'h80);
      wr(8'hCF, 8'h00);
      rd(8'hCF, 8'h15);
      rd(8'hC8, 8'h00);
      $display("test registers done");
   endtask : t_regs
   task automatic gchk(input logic [11:0] pend, input logic [11:0] e);
      q_pend = pend;
      clk_n(2);
      chk("q_grant", {4'h0, e}, {4'h0, q_grant});
   endtask : gchk
   task automatic t_order();
      do_reset();
      gchk(12'hFFF, 12'h888);
      gchk(12'h777, 12'h444);
      gchk(12'h333, 12'h222);
      gchk(12'h111, 12'h111);
      wt_allow = 12'hBBB;
      gchk(12'h666, 12'h222);
      four_q_mode = 3'h5;
      gchk(12'hDDD, 12'h818);
      four_q_mode = 3'h0;
      gchk(12'hFFF, 12'h222);
      gchk(12'hDDD, 12'h111);
      $display("test queue order done");
   endtask : t_order
   // one tick is 40 cycles; a byte costs 8000 milli-bits
   // 15030-cycle window: 375 ticks, last one followed by time to drain its credit
   function automatic int exp_bytes(input int c);
      if (c == 0 || c == 100) begin
         return 15030;
      end
      return (c < 100 ? c * 1000 : (c - 100) * 64) * 375 / 8000;
   endfunction : exp_bytes
   task automatic t_rate(input logic [6:0] c2, input logic [6:0] c3, input logic [6:0] c4);
      logic [6:0] c [3];
      int n [3];
      int e;
      c = '{c2, c3, c4};
      n = '{0, 0, 0};
      do_reset();
      four_q_mode = 3'h7;
      q_pend = 12'h888;
      for (int p = 0; p < 3; p++) begin
         wr(8'hCE + 8'(16 * p), {1'b0, c[p]});
      end
      repeat (15030) begin
         clk_n(1);
         for (int p = 0; p < 3; p++) begin
            n[p] += int'(q_grant[4 * p + 3]);
         end
      end
      // tick phase against the window leaves one byte of slack
      for (int p = 0; p < 3; p++) begin
         e = exp_bytes(int'(c[p]));
         chk("bytes", 16'(e), (n[p] >= e - 1 && n[p] <= e + 1) ? 16'(e) : 16'(n[p]));
      end
      q_pend = 12'h000;
      $display("test rate caps done");
   endtask : t_rate
   initial begin
      do_reset();
      t_regs();
      t_order();
      t_rate(7'h01, 7'h65, 7'h64);
      t_rate(7'h63, 7'h66, 7'h67);
      end_of_test();
   end
endmodule : erl_regs_bench
`default_nettype wire
